// ==== src/lsc_link_opt.sv ====
`timescale 1ns/1ps
`default_nettype none
module lsc_link_opt (
   // Clock and reset.
   input  wire logic            core_clk,
   input  wire logic            nrst,
   // Register access from the management logic.
   input  wire logic [4:0]      reg_addr,
   input  wire logic            reg_wr,
   input  wire logic            reg_rd,
   input  wire logic [15:0]     reg_wdata,
   output logic [15:0]          reg_rdata,
   // Config-done write strobe from the first strap control register.
   input  wire logic            cfg_done,
   // Criteria from the signal path.
   input  wire lsc_pkg::lsc_evt_t evt_in,
   // Symbol path fifth bits.
   input  wire logic            test_data_pin,
   input  wire logic            rx_sym4,
   input  wire logic            rx_err_in,
   output logic                 tx_sym4,
   output logic                 receive_error_pin,
   // Results.
   output logic                 strap_rst_pulse,
   output lsc_pkg::lsc_strap_t  strap,
   output logic                 link_drop,
   output lsc_pkg::lsc_evt_t    drop_cause
);
   import lsc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Register and strap latch.
   logic [15:0] link_options_strap_ctrl;
   logic [15:0] next_ctrl;
   logic [15:0] next_rdata;
   logic        next_pulse;
   lsc_strap_t  next_strap;
   logic        addr_hit;

   // Writes drop reserved bits; working straps only change on the internal pulse.
   always_comb begin
      addr_hit   = (reg_addr == LSC_ADDR_LINK_OPT);
      next_ctrl  = link_options_strap_ctrl;
      next_rdata = 16'h0000;
      if (reg_wr && addr_hit) begin
         next_ctrl = reg_wdata & LSC_WRITE_MASK;
      end
      if (reg_rd && addr_hit) begin
         next_rdata = link_options_strap_ctrl & LSC_WRITE_MASK;
      end
      next_pulse = cfg_done;
      next_strap = strap;
      if (strap_rst_pulse) begin
         next_strap.pol_swap    = link_options_strap_ctrl[LSC_BIT_POL];
         next_strap.mdix_swap   = link_options_strap_ctrl[LSC_BIT_MDIX];
         next_strap.port_mirror = link_options_strap_ctrl[LSC_BIT_POL] &
                                  link_options_strap_ctrl[LSC_BIT_MDIX];
         next_strap.bypass_4b5b = link_options_strap_ctrl[LSC_BIT_BYPASS];
      end
   end

   // Register stage for the control group.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         link_options_strap_ctrl <= LSC_RESET_VAL;
         reg_rdata               <= 16'h0000;
         strap_rst_pulse         <= 1'b0;
         strap                   <= '0;
      end else begin
         link_options_strap_ctrl <= next_ctrl;
         reg_rdata               <= next_rdata;
         strap_rst_pulse         <= next_pulse;
         strap                   <= next_strap;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Fifth symbol bits. The test-data pin is asynchronous, so it is synchronised.
   logic tdi_meta;
   logic tdi_sync;
   logic next_tx4;
   logic next_rx_err_pin;

   always_comb begin
      next_tx4        = strap.bypass_4b5b ? tdi_sync : 1'b0;
      next_rx_err_pin = strap.bypass_4b5b ? rx_sym4 : rx_err_in;
   end

   // Register stage for the symbol path.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         tdi_meta          <= 1'b0;
         tdi_sync          <= 1'b0;
         tx_sym4           <= 1'b0;
         receive_error_pin <= 1'b0;
      end else begin
         tdi_meta          <= test_data_pin;
         tdi_sync          <= tdi_meta;
         tx_sym4           <= next_tx4;
         receive_error_pin <= next_rx_err_pin;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Window timer and counted criteria.
   localparam logic [6:0] WIN_LAST = 7'(LSC_WINDOW_CYC - 1);
   localparam logic [6:0] CNT_MAX  = 7'h7f;
   logic [6:0] win_cnt;
   logic [6:0] next_win;
   logic       win_start;
   logic [2:0] cnt_evt;
   logic [2:0] cnt_en;
   logic [2:0] cnt_trip;
   logic [6:0] cnt      [3];
   logic [6:0] next_cnt [3];
   logic [6:0] cnt_thr  [3];

   // Windows run back to back; a window starts when the timer is at zero.
   always_comb begin
      win_start = (win_cnt == 7'h00);
      next_win  = (win_cnt == WIN_LAST) ? 7'h00 : win_cnt + 7'h01;
      cnt_evt   = {evt_in.rx_err, evt_in.mlt3_viol, evt_in.low_snr};
      cnt_en    = {link_options_strap_ctrl[LSC_BIT_RX_ERR],
                   link_options_strap_ctrl[LSC_BIT_MLT3],
                   link_options_strap_ctrl[LSC_BIT_SNR]};
      cnt_thr[2] = LSC_THR_RX_ERR;
      cnt_thr[1] = LSC_THR_MLT3;
      cnt_thr[0] = LSC_THR_SNR;
   end

   // Each counter restarts with the current event at a window start and saturates.
   for (genvar i = 0; i < 3; i++) begin : g_cnt
      always_comb begin
         if (win_start) begin
            next_cnt[i] = {6'h00, cnt_evt[i]};
         end else if (cnt_evt[i] && cnt[i] != CNT_MAX) begin
            next_cnt[i] = cnt[i] + 7'h01;
         end else begin
            next_cnt[i] = cnt[i];
         end
         cnt_trip[i] = cnt_en[i] && (next_cnt[i] >= cnt_thr[i]);
      end

      always_ff @(posedge core_clk or negedge nrst) begin
         if (!nrst) begin
            cnt[i] <= 7'h00;
         end else begin
            cnt[i] <= next_cnt[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Link-drop decision. Enables act live, so a cleared bit stops dropping at once.
   lsc_evt_t next_cause;

   always_comb begin
      next_cause.descr_loss  = link_options_strap_ctrl[LSC_BIT_DESCR] & evt_in.descr_loss;
      next_cause.rx_err      = cnt_trip[2];
      next_cause.mlt3_viol   = cnt_trip[1];
      next_cause.low_snr     = cnt_trip[0];
      next_cause.energy_loss = link_options_strap_ctrl[LSC_BIT_ENERGY] &
                               evt_in.energy_loss;
   end

   // Register stage for the decision.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         win_cnt    <= 7'h00;
         drop_cause <= '0;
         link_drop  <= 1'b0;
      end else begin
         win_cnt    <= next_win;
         drop_cause <= next_cause;
         link_drop  <= |next_cause;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.
   rsvd_read_zero_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (reg_rdata[15:11] == 5'h00) && (reg_rdata[9:7] == 3'h0))
      else $error("reserved bits read nonzero");

   strap_pulse_a: assert property (@(posedge core_clk) disable iff (!nrst)
      cfg_done |=> strap_rst_pulse ##1 (strap.pol_swap == $past(link_options_strap_ctrl[6])))
      else $error("strap latch after config done wrong");

   mirror_both_a: assert property (@(posedge core_clk) disable iff (!nrst)
      strap.port_mirror == (strap.pol_swap && strap.mdix_swap))
      else $error("port mirror does not match swaps");

   descr_drop_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (link_options_strap_ctrl[10] && evt_in.descr_loss) |=> (link_drop && drop_cause.descr_loss))
      else $error("no drop on descrambler loss");

   energy_drop_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (!link_options_strap_ctrl[0] || !evt_in.energy_loss) |=> !drop_cause.energy_loss)
      else $error("energy drop without cause");

   rx_err_trip_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (link_options_strap_ctrl[3] && !win_start && cnt[2] == 7'h1f && evt_in.rx_err)
      |=> link_drop && drop_cause.rx_err)
      else $error("no drop at 32 receive errors");

   snr_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (cnt[0] < 7'h13) |=> !drop_cause.low_snr)
      else $error("snr drop below threshold");

   // The sampled reset term keeps the release edge, still a reset edge, from starting a window.
   window_clear_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (nrst && win_start) |=> (cnt[1] <= 7'h01) ##[99:99] (win_cnt == 7'h00))
      else $error("window clear or length wrong");

   bypass_receive_error_pin_a: assert property (@(posedge core_clk) disable iff (!nrst)
      strap.bypass_4b5b |=> receive_error_pin == $past(rx_sym4))
      else $error("fifth receive bit not routed");

   drop_or_a: assert property (@(posedge core_clk) disable iff (!nrst)
      link_drop == (|drop_cause))
      else $error("drop is not OR of causes");

endmodule // lsc_link_opt
`default_nettype wire

// ==== src/lsc_pkg.sv ====
package lsc_pkg;

   // Register map.
   localparam logic [4:0]  LSC_ADDR_LINK_OPT = 5'h0b;
   localparam logic [15:0] LSC_RESET_VAL     = 16'h0000;
   localparam logic [15:0] LSC_WRITE_MASK    = 16'h047f;

   // Field positions.
   localparam int LSC_BIT_DESCR  = 10;
   localparam int LSC_BIT_POL    = 6;
   localparam int LSC_BIT_MDIX   = 5;
   localparam int LSC_BIT_BYPASS = 4;
   localparam int LSC_BIT_RX_ERR = 3;
   localparam int LSC_BIT_MLT3   = 2;
   localparam int LSC_BIT_SNR    = 1;
   localparam int LSC_BIT_ENERGY = 0;

   // Timing: counting window in its own unit and derived cycle count.
   localparam int LSC_CLK_PERIOD_NS = 100;
   localparam int LSC_WINDOW_NS     = 10000;
   localparam int LSC_WINDOW_CYC    = LSC_WINDOW_NS / LSC_CLK_PERIOD_NS;

   // Count thresholds per counted criterion.
   localparam logic [6:0] LSC_THR_RX_ERR = 7'h20;
   localparam logic [6:0] LSC_THR_MLT3   = 7'h14;
   localparam logic [6:0] LSC_THR_SNR    = 7'h14;

   // Link-down criteria in status order.
   typedef struct packed {
      logic descr_loss;
      logic rx_err;
      logic mlt3_viol;
      logic low_snr;
      logic energy_loss;
   } lsc_evt_t;

   // Working copies of the latched strap bits.
   typedef struct packed {
      logic pol_swap;
      logic mdix_swap;
      logic port_mirror;
      logic bypass_4b5b;
   } lsc_strap_t;

endpackage

// ==== testbench/lsc_proc_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module lsc_proc_model (
   // Clock.
   input  wire logic        core_clk,
   // Management requests.
   output var logic  [4:0]  reg_addr,
   output var logic         reg_wr,
   output var logic         reg_rd,
   output var logic  [15:0] reg_wdata,
   output var logic         cfg_done,
   // Read data.
   input  wire logic [15:0] reg_rdata
);
   // Idle values; the address parks away from the register.
   initial begin
      reg_addr = 5'h1f;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 16'h0000;
      cfg_done = 1'b0;
   end
   // One write; released data is inverted so stale values never look valid.
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask
   // One read; data is taken in the cycle after the read edge.
   task automatic rd(input logic [4:0] a, output logic [15:0] q);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
   endtask
   // Config-done comes only after the strap writes.
   // Bypass is only asked for with the full interface mode in use.
   task automatic done();
      @(posedge core_clk);
      cfg_done <= 1'b1;
      @(posedge core_clk);
      cfg_done <= 1'b0;
      #1;
   endtask
endmodule // lsc_proc_model
`default_nettype wire

// ==== testbench/strap_config_fast_link_down_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module strap_config_fast_link_down_tb;
   import lsc_pkg::*;
   logic        core_clk, nrst, reg_wr, reg_rd, cfg_done, test_data_pin;
   logic        rx_sym4, rx_err_in, tx_sym4, receive_error_pin, strap_rst_pulse, link_drop;
   logic [4:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, q;
   lsc_evt_t    evt_in, drop_cause;
   lsc_strap_t  strap;
   int          error_cnt, total_checks, cyc;
   localparam logic [4:0] A = LSC_ADDR_LINK_OPT;

   lsc_link_opt uut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cfg_done(cfg_done),
      .evt_in(evt_in), .test_data_pin(test_data_pin), .rx_sym4(rx_sym4),
      .rx_err_in(rx_err_in), .tx_sym4(tx_sym4), .receive_error_pin(receive_error_pin),
      .strap_rst_pulse(strap_rst_pulse), .strap(strap), .link_drop(link_drop),
      .drop_cause(drop_cause));
   lsc_proc_model proc (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .cfg_done(cfg_done), .reg_rdata(reg_rdata));

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and a cycle count since reset, used to place bursts inside a window.
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) cyc <= 0;
      else cyc <= cyc + 1;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Reset value, reserved bits, unmapped address; writes alone leave straps.
   task automatic t_reg();
      proc.rd(A, q);
      chk(q, LSC_RESET_VAL);
      proc.wr(A, 16'hffff);
      proc.rd(A, q);
      chk(q, 16'h047f);
      proc.rd(5'h0a, q);
      chk(q, 16'h0000);
      chk(16'(strap), 16'h0000);
      $display("t_reg done");
   endtask
   // Each strap pattern is latched only by the config-done pulse.
   task automatic t_strap();
      logic [15:0] w [4] = '{16'h0070, 16'h0040, 16'h0020, 16'h0010};
      logic [3:0]  e [4] = '{4'hf, 4'h8, 4'h4, 4'h1};
      for (int i = 0; i < 4; i++) begin
         proc.wr(A, w[i]);
         proc.done();
         chk(16'(strap_rst_pulse), 16'h0001);
         @(posedge core_clk);
         #1 chk(16'({strap_rst_pulse, strap}), 16'(e[i]));
      end
      $display("t_strap done");
   endtask
   // Fifth symbol bits with bypass latched, then normal error path.
   task automatic t_bypass();
      @(posedge core_clk);
      rx_sym4 <= 1'b1;
      test_data_pin <= 1'b1;
      repeat (4) @(posedge core_clk);
      #1 chk(16'({tx_sym4, receive_error_pin}), 16'h0003);
      proc.wr(A, 16'h0000);
      proc.done();
      @(posedge core_clk);
      rx_sym4 <= 1'b0;
      rx_err_in <= 1'b1;
      repeat (4) @(posedge core_clk);
      #1 chk(16'({tx_sym4, receive_error_pin}), 16'h0001);
      $display("t_bypass done");
   endtask
   // Level criteria under live enables.
   task automatic t_lvl();
      logic [15:0] w [4] = '{16'h0401, 16'h0400, 16'h0001, 16'h0000};
      logic [4:0]  e [4] = '{5'h11, 5'h10, 5'h01, 5'h00};
      @(posedge core_clk);
      evt_in <= 5'h11;
      for (int i = 0; i < 4; i++) begin
         proc.wr(A, w[i]);
         @(posedge core_clk);
         #1 chk(16'({link_drop, drop_cause}), 16'({|e[i], e[i]}));
      end
      @(posedge core_clk);
      evt_in <= 5'h00;
      $display("t_lvl done");
   endtask
   // Burst of counted events inside one window, one short of or at the threshold.
   task automatic t_cnt(input int b, input int miss);
      int n;
      logic [4:0] e;
      n = (b == 3) ? int'(LSC_THR_RX_ERR) : (b == 2) ? int'(LSC_THR_MLT3) : int'(LSC_THR_SNR);
      n = n - miss;
      e = (miss == 0) ? (5'h01 << b) : 5'h00;
      @(posedge core_clk);
      while (cyc % 100 != 5) @(posedge core_clk);
      repeat (n) begin
         evt_in[b] <= 1'b1;
         @(posedge core_clk);
      end
      evt_in[b] <= 1'b0;
      @(posedge core_clk);
      #1 chk(16'({link_drop, drop_cause}), 16'({|e, e}));
      repeat (100) @(posedge core_clk);
      #1 chk(16'(drop_cause), 16'h0000);
      $display("t_cnt %0d %0d done", b, miss);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence; the watchdog cuts a hang short.
   initial begin
      nrst = 1'b0;
      evt_in = 5'h00;
      test_data_pin = 1'b0;
      rx_sym4 = 1'b0;
      rx_err_in = 1'b0;
      repeat (4) @(posedge core_clk);
      nrst <= 1'b1;
      t_reg();
      t_strap();
      t_bypass();
      t_lvl();
      proc.wr(A, 16'h000e);
      for (int b = 3; b > 0; b--) begin
         t_cnt(b, 1);
         t_cnt(b, 0);
      end
      end_of_test();
   end
   initial begin
      #(5000 * 100);
      error_cnt++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      end_of_test();
   end
endmodule // strap_config_fast_link_down_tb
`default_nettype wire
